// ### verilog/sdram_lowpower_irq_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "sdram_lp_cfg.svh"

module sdram_lowpower_irq_regs
    import sdram_lp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [31:0]       WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [31:0]       RDATA_O,
    input  wire logic              ACC_VALID_I,
    input  wire logic              ACC_SEQ_I,
    output logic                   ACC_READY_O,
    input  wire logic              INIT_EMR_REQ_I,
    input  wire logic              EMR_LOAD_REQ_I,
    input  wire logic              REFRESH_ERR_I,
    input  wire logic              LINK_CLK_I,
    output mem_cmd_s               MEM_CMD_O,
    output logic                   MEM_CLK_O,
    output logic                   MEM_CKE_O,
    output logic      [3:0]        SR_BANK_EN_O,
    output logic      [3:0]        COL_BITS_O,
    output logic                   LP_MEMORY_O,
    output logic                   IRQ_O
);

    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    // The decoder compares against 8-bit offsets.
    if (ADDR_W != 8) begin : g_bad_addr_w
        $error("ADDR_W must be 8 for this register decoder.");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic        decode_en;
    lp_ctrl_s    lp_ctrl;
    logic        irq_mask;
    logic        refresh_error_flag;
    logic [1:0]  memory_type_field;
    logic [1:0]  col_code;
    logic [31:0] rdata;
    pwr_state_e  state;
    pwr_state_e  next_state;
    logic        decode_done;
    logic [7:0]  idle_cnt;
    logic        init_done;
    logic        emr_dirty;
    // The memory clock keeps running through an extended mode load.
    mem_cmd_s    cmd;
    mem_cmd_s    next_cmd;
    logic        cke;
    logic        clk_run;
    logic        link_meta;
    logic        link_sync;
    logic        link_prev;
    logic        mem_clk;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // One select line per register offset.
    wire sel_decode  = (ADDR_I == `OFF_DECODE_CTRL);
    wire sel_lp      = (ADDR_I == `OFF_LOW_POWER_CTRL);
    wire sel_en_set  = (ADDR_I == `OFF_IRQ_EN_SET);
    wire sel_en_clr  = (ADDR_I == `OFF_IRQ_EN_CLR);
    wire sel_mask    = (ADDR_I == `OFF_IRQ_MASK);
    wire sel_status  = (ADDR_I == `OFF_IRQ_STATUS);
    wire sel_type    = (ADDR_I == `OFF_MEM_TYPE);
    wire sel_col     = (ADDR_I == `OFF_COL_CFG);

    // Write strobes and the status read strobe, qualified by the decoder.
    wire wr_decode   = WR_I && sel_decode;
    wire wr_lp       = WR_I && sel_lp;
    wire wr_en_set   = WR_I && sel_en_set;
    wire wr_en_clr   = WR_I && sel_en_clr;
    wire wr_type     = WR_I && sel_type;
    wire wr_col      = WR_I && sel_col;
    wire rd_status   = RD_I && sel_status;

    // Incoming low-power register value as fields.
    lp_ctrl_s lp_wdata;
    assign lp_wdata.timeout = WDATA_I[`POS_TIMEOUT_LO +: 2];
    assign lp_wdata.drive   = WDATA_I[`POS_DS_LO +: 2];
    assign lp_wdata.temp_comp_refresh    = WDATA_I[`POS_TEMP_COMP_REFRESH_LO +: 2];
    assign lp_wdata.partial_array_refresh    = WDATA_I[`POS_PARTIAL_ARRAY_REFRESH_LO +: 3];
    assign lp_wdata.mode    = lp_mode_e'(WDATA_I[`POS_LOW_POWER_CONFIG_LO +: 2]);

    // A write that alters any extended-mode field after initialization.
    wire emr_fields_change = wr_lp && init_done &&
                             ((lp_wdata.drive != lp_ctrl.drive) ||
                              (lp_wdata.temp_comp_refresh  != lp_ctrl.temp_comp_refresh)  ||
                              (lp_wdata.partial_array_refresh  != lp_ctrl.partial_array_refresh));

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Read multiplexer; write-only and unmapped offsets read as zero.
    wire [31:0] lp_rword = {18'h0_0000, lp_ctrl.timeout, lp_ctrl.drive, lp_ctrl.temp_comp_refresh,
                            1'b0, lp_ctrl.partial_array_refresh, 2'b00, lp_ctrl.mode};
    wire [31:0] next_rdata =
        sel_decode ? {31'h0000_0000, decode_en}          :
        sel_lp     ? lp_rword                            :
        sel_mask   ? {31'h0000_0000, irq_mask}           :
        sel_status ? {31'h0000_0000, refresh_error_flag} :
        sel_type   ? {30'h0000_0000, memory_type_field}  :
        sel_col    ? {30'h0000_0000, col_code}           :
                     `RST_REG_WORD;

    // Read data register, valid only in the cycle after the read strobe.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata <= `RST_REG_WORD;
        end else if (RD_I) begin
            rdata <= next_rdata;
        end else begin
            rdata <= `RST_REG_WORD;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // Software-written configuration.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            decode_en         <= 1'b0;
            lp_ctrl           <= lp_ctrl_s'(11'h000);
            memory_type_field <= 2'h0;
            col_code          <= `RST_COL_CODE;
        end else begin
            if (wr_decode) begin
                decode_en <= WDATA_I[`POS_DECODE_EN];
            end
            if (wr_lp) begin
                lp_ctrl <= lp_wdata;
            end
            if (wr_type) begin
                memory_type_field <= WDATA_I[`POS_MEM_TYPE_LO +: 2];
            end
            if (wr_col) begin
                col_code <= WDATA_I[`POS_COL_LO +: 2];
            end
        end
    end

    // Column bits: 8 plus the code.
    assign COL_BITS_O = `COL_BITS_BASE + {2'b00, col_code};

    // Only code 1 selects low-power memory; reserved codes act as SDRAM.
    wire lp_memory = (memory_type_field == 2'h1);
    assign LP_MEMORY_O = lp_memory;

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Mask set and clear by one-bits; status set wins over the read clear.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_mask           <= 1'b0;
            refresh_error_flag <= 1'b0;
        end else begin
            if (wr_en_set && WDATA_I[`POS_REFRESH_ERR]) begin
                irq_mask <= 1'b1;
            end else if (wr_en_clr && WDATA_I[`POS_REFRESH_ERR]) begin
                irq_mask <= 1'b0;
            end
            if (REFRESH_ERR_I) begin
                refresh_error_flag <= 1'b1;
            end else if (rd_status) begin
                refresh_error_flag <= 1'b0;
            end
        end
    end

    // Level interrupt from the unmasked status bit.
    assign IRQ_O = refresh_error_flag && irq_mask;

    // ------------------------------------------------------------------------
    // Access path and idle timer
    // ------------------------------------------------------------------------
    // A non-sequential access waits one decode cycle when enabled.
    wire need_decode = decode_en && !ACC_SEQ_I && !decode_done;
    assign ACC_READY_O = (state == ST_ACTIVE) && !need_decode;
    wire acc_taken = ACC_VALID_I && ACC_READY_O;

    // Idle threshold per entry delay code; code 3 never enters.
    wire [7:0] idle_limit = (lp_ctrl.timeout == 2'h1) ? `IDLE_CYC_CODE1 :
                            (lp_ctrl.timeout == 2'h2) ? `IDLE_CYC_CODE2 :
                                                        8'h00;
    wire timeout_ok  = (lp_ctrl.timeout != 2'h3) && (idle_cnt >= idle_limit);
    wire enter_lp    = (state == ST_ACTIVE) && !ACC_VALID_I && timeout_ok &&
                       (lp_ctrl.mode != LP_OFF);

    // Decode cycle marker and idle counter since the last transfer.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            decode_done <= 1'b0;
            idle_cnt    <= 8'h00;
        end else begin
            if (acc_taken) begin
                decode_done <= 1'b0;
            end else if (ACC_VALID_I && need_decode && (state == ST_ACTIVE)) begin
                decode_done <= 1'b1;
            end
            if (ACC_VALID_I || (state != ST_ACTIVE)) begin
                idle_cnt <= 8'h00;
            end else if (idle_cnt != 8'hFF) begin
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Extended mode bookkeeping
    // ------------------------------------------------------------------------
    // Extended mode word: partial, temperature, drive; all else zero.
    wire [12:0] emr_word = (13'h0000 | ({10'h000, lp_ctrl.partial_array_refresh} << `POS_EMR_PARTIAL_ARRAY_REFRESH)
                                     | ({11'h000, lp_ctrl.temp_comp_refresh} << `POS_EMR_TEMP_COMP_REFRESH)
                                     | ({11'h000, lp_ctrl.drive} << `POS_EMR_DS));

    // Extended load requests served only from the active state.
    wire init_emr  = INIT_EMR_REQ_I && lp_memory;
    wire emr_issue = (state == ST_ACTIVE) && (init_emr || EMR_LOAD_REQ_I);

    // Tracks initialization and fields changed since the last load.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            init_done <= 1'b0;
            emr_dirty <= 1'b0;
        end else begin
            if (INIT_EMR_REQ_I) begin
                init_done <= 1'b1;
            end
            if (emr_fields_change) begin
                emr_dirty <= 1'b1;
            end else if ((next_cmd.code == CMD_EMR_LOAD) && !wr_lp) begin
                emr_dirty <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------------
    // Chooses the next state and the command sent toward the memory.
    always_comb begin
        next_state    = state;
        next_cmd.code = CMD_NONE;
        next_cmd.emr  = cmd.emr;
        case (state)
            ST_ACTIVE: begin
                if (emr_issue) begin
                    next_cmd.code = CMD_EMR_LOAD;
                    next_cmd.emr  = emr_word;
                end else if (enter_lp) begin
                    case (lp_ctrl.mode)
                        LP_SELF_REF: begin
                            if (emr_dirty && lp_memory) begin
                                next_state    = ST_EMR;
                                next_cmd.code = CMD_EMR_LOAD;
                                next_cmd.emr  = emr_word;
                            end else begin
                                next_state    = ST_SELF_REF;
                                next_cmd.code = CMD_SELF_REF;
                            end
                        end
                        LP_POWER_DOWN: begin
                            next_state    = ST_POWER_DN;
                            next_cmd.code = CMD_POWER_DN;
                        end
                        LP_DEEP_PD: begin
                            if (lp_memory) begin
                                next_state    = ST_DEEP_PD;
                                next_cmd.code = CMD_DEEP_PD;
                            end
                        end
                        default: begin
                            next_state = ST_ACTIVE;
                        end
                    endcase
                end
            end
            ST_EMR: begin
                next_state    = ST_SELF_REF;
                next_cmd.code = CMD_SELF_REF;
            end
            ST_SELF_REF, ST_POWER_DN, ST_DEEP_PD: begin
                if (ACC_VALID_I || (lp_ctrl.mode == LP_OFF)) begin
                    next_state    = ST_ACTIVE;
                    next_cmd.code = CMD_LP_EXIT;
                end
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // State, command and clock-enable registers.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state       <= ST_ACTIVE;
            cmd         <= mem_cmd_s'(16'h0000);
            cke         <= 1'b1;
        end else begin
            state       <= next_state;
            cmd         <= next_cmd;
            // Clock enable stays high while the extended mode word is loaded.
            cke         <= (next_state == ST_ACTIVE) || (next_state == ST_EMR);
        end
    end

    assign MEM_CMD_O = cmd;
    assign MEM_CKE_O = cke;

    // Refresh bank enables: in self refresh only the partial-array banks.
    wire [3:0] partial_array_refresh_banks = (lp_ctrl.partial_array_refresh == 3'h1) ? 4'h3 :
                            (lp_ctrl.partial_array_refresh == 3'h2) ? 4'h1 :
                                                     4'hF;
    assign SR_BANK_EN_O = (state == ST_SELF_REF) ? partial_array_refresh_banks : 4'hF;

    // ------------------------------------------------------------------------
    // Memory clock
    // ------------------------------------------------------------------------
    // Two-stage synchroniser on the link clock, then an edge register.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
            link_prev <= 1'b0;
        end else begin
            link_meta <= LINK_CLK_I;
            link_sync <= link_meta;
            link_prev <= link_sync;
        end
    end

    // Clock gating changes only on a falling edge so no runt pulse leaves.
    wire link_fall = link_prev && !link_sync;
    wire want_run  = (state != ST_SELF_REF) && (state != ST_DEEP_PD);

    // Gate state and gated clock copy.
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            clk_run <= 1'b1;
            mem_clk <= 1'b0;
        end else begin
            if (link_fall) begin
                clk_run <= want_run;
            end
            mem_clk <= link_sync && clk_run;
        end
    end

    assign MEM_CLK_O = mem_clk;
    assign RDATA_O   = rdata;

endmodule : sdram_lowpower_irq_regs

`default_nettype wire

// ### verilog/sdram_lp_cfg.svh
`ifndef SDRAM_LP_CFG_SVH
`define SDRAM_LP_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_DECODE_CTRL     8'h0C
`define OFF_LOW_POWER_CTRL  8'h10
`define OFF_IRQ_EN_SET      8'h14
`define OFF_IRQ_EN_CLR      8'h18
`define OFF_IRQ_MASK        8'h1C
`define OFF_IRQ_STATUS      8'h20
`define OFF_MEM_TYPE        8'h24
`define OFF_COL_CFG         8'h28

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define POS_DECODE_EN       0
`define POS_LOW_POWER_CONFIG_LO         0
`define POS_PARTIAL_ARRAY_REFRESH_LO         4
`define POS_TEMP_COMP_REFRESH_LO         8
`define POS_DS_LO           10
`define POS_TIMEOUT_LO      12
`define POS_REFRESH_ERR     0
`define POS_MEM_TYPE_LO     0
`define POS_COL_LO          0
`define POS_EMR_PARTIAL_ARRAY_REFRESH        0
`define POS_EMR_TEMP_COMP_REFRESH        3
`define POS_EMR_DS          5

// ----------------------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------------------
`define RST_REG_WORD        32'h0000_0000
`define RST_COL_CODE        2'h0
`define COL_BITS_BASE       4'h8
`define IDLE_CYC_CODE1      8'h40
`define IDLE_CYC_CODE2      8'h80

`endif

// ### verilog/sdram_lp_pkg.sv
package sdram_lp_pkg;

    // Low-power configuration codes.
    typedef enum logic [1:0] {
        LP_OFF        = 2'b00,
        LP_SELF_REF   = 2'b01,
        LP_POWER_DOWN = 2'b10,
        LP_DEEP_PD    = 2'b11
    } lp_mode_e;

    // Commands sent toward the memory.
    typedef enum logic [2:0] {
        CMD_NONE      = 3'b000,
        CMD_EMR_LOAD  = 3'b001,
        CMD_SELF_REF  = 3'b010,
        CMD_POWER_DN  = 3'b011,
        CMD_DEEP_PD   = 3'b100,
        CMD_LP_EXIT   = 3'b101
    } mem_cmd_e;

    // Controller power state.
    typedef enum logic [2:0] {
        ST_ACTIVE     = 3'b000,
        ST_EMR        = 3'b001,
        ST_SELF_REF   = 3'b010,
        ST_POWER_DN   = 3'b011,
        ST_DEEP_PD    = 3'b100
    } pwr_state_e;

    // Fields of the low-power control register.
    typedef struct packed {
        logic [1:0] timeout;
        logic [1:0] drive;
        logic [1:0] temp_comp_refresh;
        logic [2:0] partial_array_refresh;
        lp_mode_e   mode;
    } lp_ctrl_s;

    // Command issued toward the memory, with the extended mode word.
    typedef struct packed {
        mem_cmd_e    code;
        logic [12:0] emr;
    } mem_cmd_s;

endpackage : sdram_lp_pkg

// ### testbench/sdram_lp_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module sdram_lp_chk
    import sdram_lp_pkg::*;
(
    input wire logic       SYS_CLK_I,
    input wire logic       RST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic       REFRESH_ERR_I,
    input wire logic       ACC_READY_O,
    input wire mem_cmd_s   MEM_CMD_O,
    input wire logic       MEM_CLK_O,
    input wire logic       MEM_CKE_O,
    input wire logic [3:0] SR_BANK_EN_O,
    input wire logic [3:0] COL_BITS_O,
    input wire logic       LP_MEMORY_O,
    input wire logic       IRQ_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    // Self-refresh entry followed by a long stretch of low clock enable.
    sequence sr_long;
        MEM_CMD_O.code == CMD_SELF_REF ##1 !MEM_CKE_O [*8] ##1 !MEM_CKE_O [*6];
    endsequence
    // Relations between the block's outputs and their causes.
    a_col_range: assert property (COL_BITS_O >= 4'h8 && COL_BITS_O <= 4'hB)
        else $error("column width out of range");
    a_irq_rise: assert property ($rose(IRQ_O) |->
        $past(REFRESH_ERR_I) || $past(WR_I && ADDR_I == 8'h14)) else $error("irq rose alone");
    a_irq_drop: assert property ($fell(IRQ_O) |->
        $past(RD_I && ADDR_I == 8'h20) || $past(WR_I && ADDR_I == 8'h18)) else $error("irq fell alone");
    a_status_clear: assert property ((RD_I && ADDR_I == 8'h20 && !REFRESH_ERR_I) |=> !IRQ_O)
        else $error("status read left irq high");
    a_lp_cke_low: assert property (
        MEM_CMD_O.code inside {CMD_SELF_REF, CMD_POWER_DN, CMD_DEEP_PD} |-> !MEM_CKE_O)
        else $error("clock enable high on entry");
    a_ready_sleep: assert property (!MEM_CKE_O |-> !ACC_READY_O)
        else $error("ready while asleep");
    a_bank_full: assert property (MEM_CKE_O |-> SR_BANK_EN_O == 4'hF)
        else $error("banks trimmed while awake");
    a_clk_stopped: assert property (sr_long |-> !MEM_CLK_O)
        else $error("memory clock runs in self refresh");
    a_deep_lp_only: assert property (MEM_CMD_O.code == CMD_DEEP_PD |-> LP_MEMORY_O)
        else $error("deep power-down on plain memory");
endmodule : sdram_lp_chk

bind sdram_lowpower_irq_regs sdram_lp_chk sdram_lp_chk_i (.*);
`default_nettype wire

// ### testbench/sdram_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Memory model
// ----------------------------------------
module sdram_model
    import sdram_lp_pkg::*;
(
    input  wire logic     clk_i,
    input  wire mem_cmd_s cmd_i,
    output logic          link_clk_o,
    output int            lp_cmds_o
);
    // Free-running link clock, phase unrelated to the system clock.
    initial begin
        link_clk_o = 1'b0;
        #137;
        forever #400 link_clk_o = ~link_clk_o;
    end
    // Counts the low-power entry commands the memory receives.
    always @(posedge clk_i) begin
        if (cmd_i.code inside {CMD_SELF_REF, CMD_POWER_DN, CMD_DEEP_PD})
            lp_cmds_o <= lp_cmds_o + 1;
    end
endmodule : sdram_model
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
// ----------------------------------------
// Bench
// ----------------------------------------
module testbench
    import sdram_lp_pkg::*;
;
    logic        SYS_CLK_I = 1'b0, RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic        ACC_VALID_I = 1'b0, ACC_SEQ_I = 1'b0, REFRESH_ERR_I = 1'b0;
    logic        INIT_EMR_REQ_I = 1'b0, EMR_LOAD_REQ_I = 1'b0, LINK_CLK_I;
    logic [7:0]  ADDR_I = 8'h00;
    logic [31:0] WDATA_I = 32'h0000_0000, RDATA_O;
    logic        ACC_READY_O, MEM_CLK_O, MEM_CKE_O, LP_MEMORY_O, IRQ_O;
    logic [3:0]  SR_BANK_EN_O, COL_BITS_O;
    mem_cmd_s    MEM_CMD_O;
    int          mismatches, cmp_count, cyc, n, lp_cmds;

    sdram_lowpower_irq_regs sdram_lowpower_irq_regs_i (.*);
    sdram_model sdram_model_i (.clk_i(SYS_CLK_I), .cmd_i(MEM_CMD_O),
        .link_clk_o(LINK_CLK_I), .lp_cmds_o(lp_cmds));

    // System clock and a ceiling on the run length.
    always #50 SYS_CLK_I = ~SYS_CLK_I;
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            print_verdict();
        end
    end

    // Bus cycles, access handshake and command wait.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        ADDR_I <= a;
        WDATA_I <= v;
        WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        WR_I <= 1'b0;
        @(posedge SYS_CLK_I);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        #1 `CHK(RDATA_O, e)
        @(posedge SYS_CLK_I);
    endtask : rd
    task automatic acc(input logic seq);
        ACC_VALID_I <= 1'b1;
        ACC_SEQ_I <= seq;
        n = 0;
        #1;
        while (ACC_READY_O !== 1'b1 && n < 300) begin
            @(posedge SYS_CLK_I);
            #1 n++;
        end
        @(posedge SYS_CLK_I);
        ACC_VALID_I <= 1'b0;
        @(posedge SYS_CLK_I);
    endtask : acc
    task automatic wcmd(input mem_cmd_e c);
        n = 0;
        #1;
        while (MEM_CMD_O.code !== c && n < 400) begin
            @(posedge SYS_CLK_I);
            #1 n++;
        end
    endtask : wcmd
    task automatic err_pulse;
        REFRESH_ERR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        REFRESH_ERR_I <= 1'b0;
        @(posedge SYS_CLK_I);
        #1;
    endtask : err_pulse

    // Scenarios.
    task automatic t_reset;
        logic [7:0] offs [8] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h30};
        `CHK(COL_BITS_O, 4'h8)
        `CHK(IRQ_O, 1'b0)
        foreach (offs[i]) rd(offs[i], 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            wr(8'h28, 32'(i));
            #1 `CHK(COL_BITS_O, 4'h8 + 4'(i))
        end
        $display("reset and column test done");
    endtask : t_reset
    task automatic t_irq;
        wr(8'h14, 32'h0);
        rd(8'h1C, 32'h0);
        wr(8'h14, 32'h1);
        rd(8'h1C, 32'h1);
        err_pulse();
        `CHK(IRQ_O, 1'b1)
        rd(8'h20, 32'h1);
        #1 `CHK(IRQ_O, 1'b0)
        rd(8'h20, 32'h0);
        wr(8'h18, 32'h0);
        rd(8'h1C, 32'h1);
        wr(8'h18, 32'h1);
        rd(8'h1C, 32'h0);
        err_pulse();
        `CHK(IRQ_O, 1'b0)
        rd(8'h20, 32'h1);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_dec;
        wr(8'h0C, 32'h1);
        rd(8'h0C, 32'h1);
        acc(1'b0);
        `CHK(n, 1)
        acc(1'b1);
        `CHK(n, 0)
        wr(8'h0C, 32'h0);
        acc(1'b0);
        `CHK(n, 0)
        repeat (150) @(posedge SYS_CLK_I);
        `CHK(lp_cmds, 0)
        $display("decode cycle test done");
    endtask : t_dec
    task automatic t_pd;
        wr(8'h10, 32'h0000_1002);
        acc(1'b1);
        wcmd(CMD_POWER_DN);
        `CHK(n inside {[62:67]}, 1'b1)
        `CHK(MEM_CKE_O, 1'b0)
        acc(1'b1);
        `CHK(n, 1)
        wr(8'h10, 32'h0000_2002);
        acc(1'b1);
        wcmd(CMD_POWER_DN);
        `CHK(n inside {[126:131]}, 1'b1)
        wr(8'h10, 32'h0);
        repeat (4) @(posedge SYS_CLK_I);
        #1 `CHK(MEM_CKE_O, 1'b1)
        $display("power-down test done");
    endtask : t_pd
    task automatic t_sr;
        wr(8'h24, 32'h1);
        #1 `CHK(LP_MEMORY_O, 1'b1)
        wr(8'h10, 32'h0000_0610);
        INIT_EMR_REQ_I <= 1'b1;
        @(posedge SYS_CLK_I);
        INIT_EMR_REQ_I <= 1'b0;
        wcmd(CMD_EMR_LOAD);
        `CHK(MEM_CMD_O.emr, 13'h0031)
        wr(8'h10, 32'h0000_0621);
        wcmd(CMD_EMR_LOAD);
        `CHK(MEM_CMD_O.emr, 13'h0032)
        @(posedge SYS_CLK_I);
        #1 `CHK(MEM_CMD_O.code, CMD_SELF_REF)
        `CHK(MEM_CKE_O, 1'b0)
        `CHK(SR_BANK_EN_O, 4'h1)
        repeat (20) @(posedge SYS_CLK_I);
        #1 `CHK(MEM_CLK_O, 1'b0)
        acc(1'b1);
        `CHK(n, 1)
        wcmd(CMD_SELF_REF);
        `CHK(n < 5, 1'b1)
        $display("self refresh test done");
    endtask : t_sr
    task automatic t_dpd;
        wr(8'h10, 32'h0000_0620);
        EMR_LOAD_REQ_I <= 1'b1;
        @(posedge SYS_CLK_I);
        EMR_LOAD_REQ_I <= 1'b0;
        wcmd(CMD_EMR_LOAD);
        `CHK(MEM_CMD_O.emr, 13'h0032)
        wr(8'h10, 32'h0000_0623);
        wcmd(CMD_DEEP_PD);
        `CHK(n < 5, 1'b1)
        `CHK(MEM_CKE_O, 1'b0)
        $display("deep power-down test done");
    endtask : t_dpd

    // Counts and verdict; ends the run.
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Main sequence.
    initial begin
        repeat (10) @(posedge SYS_CLK_I);
        RST_I <= 1'b0;
        @(posedge SYS_CLK_I);
        t_reset();
        t_irq();
        t_dec();
        t_pd();
        t_sr();
        t_dpd();
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
